// ==== amp_pkg.sv ====
// Purpose: constants for the asynchronous page-mode memory port host
// Assumes: 125 MHz host clock, x32 data, 28-bit word address
// Notes: times in ns as printed, cycle counts derived from clock period
package amp_pkg;
    localparam int ADDR_W = 28;
    localparam int PIN_ADDR_W = 27;
    localparam int DATA_W = 32;
    localparam int TMR_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam int CS_SEL_BIT = 27;
    localparam real CLK_PERIOD_NS = 8.0;

    // pin timing, ns
    localparam real T_WLWH_NS = 25.0;
    localparam real T_AVAV_NS = 45.0;
    localparam real T_WHAX_NS = 12.0;
    localparam real T_ACC_NS = 45.0;
    localparam real T_HIZ_NS = 15.0;
    localparam real T_EH_NS = 10.0;
    localparam real T_EP_NS = 45.0;
    localparam real T_PGSL_NS = 10.0;
    localparam real T_PGSH_NS = 10.0;
    localparam real T_PGH_NS = 45.0;
    localparam real T_AAP_NS = 15.0;
    localparam real T_WP_NS = 7.5;
    localparam real T_WPH_NS = 7.5;

    // least time to whole cycles, rounded up, never below one
    function automatic int ns2cyc(input real t);
        int n;
        n = $rtoi(t / CLK_PERIOD_NS);
        if (n * CLK_PERIOD_NS < t) n = n + 1;
        if (n < 1) n = 1;
        return n;
    endfunction

    function automatic int imax(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int WLO_CYC = ns2cyc(T_WLWH_NS);
    localparam int WHI_CYC = ns2cyc(T_WHAX_NS);
    localparam int ACC_CYC = ns2cyc(T_ACC_NS) + SYNC_STAGES;
    localparam int AAP_CYC = ns2cyc(T_AAP_NS) + SYNC_STAGES;
    localparam int END_CYC = imax(ns2cyc(T_EH_NS), ns2cyc(T_HIZ_NS));
    localparam int EP_CYC = ns2cyc(T_EP_NS);
    localparam int PGSL_CYC = ns2cyc(T_PGSL_NS);
    localparam int PGX_CYC = imax(ns2cyc(T_PGSH_NS), ns2cyc(T_PGH_NS));
    localparam int PWLO_CYC = ns2cyc(T_WP_NS);
    localparam int PWHI_CYC = ns2cyc(T_WPH_NS);
    localparam int CYC_CYC = ns2cyc(T_AVAV_NS);

    typedef enum logic [3:0] {
        AMP_IDLE = 4'h0,
        AMP_MODE = 4'h1,
        AMP_SETUP = 4'h2,
        AMP_WLO = 4'h3,
        AMP_WHI = 4'h4,
        AMP_RWAIT = 4'h5,
        AMP_PHOLD = 4'h6,
        AMP_PWLO = 4'h7,
        AMP_PWHI = 4'h8,
        AMP_PRWAIT = 4'h9,
        AMP_END = 4'ha
    } amp_state_t;
endpackage

// ==== amp_host_ctrl.sv ====
// Purpose: host controller driving the asynchronous page-mode memory pins
// Assumes: one outstanding access, read data returned via 2-entry buffer
// Notes: address bit 27 picks the upper chip select on the big part
//
// Overview of operation
// - output gate held high during writes
// - write strobe held high during reads
// - address set no later than strobe fall
// - write low 25 ns, cycle 45 ns
// - address valid 30 ns before write end
// - page select low 10 ns before select
// - leave page: high 10/45 ns
// - page write pulses write adjacent words
// - page write pulses 7.5 ns low/high
// - select low until page write completes
// - page select low 45, high 10 ns
`timescale 1ns/10ps
module amp_host_ctrl import amp_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_page,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    input wire logic rsp_ready,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic [PIN_ADDR_W-1:0] mem_addr,
    output logic chip_select_lower_n,
    output logic chip_select_upper_n,
    output logic mem_we_n,
    output logic mem_oe_n,
    output logic page_select_n,
    output logic [DATA_W-1:0] mem_dq_o,
    output logic mem_dq_oe,
    input wire logic [DATA_W-1:0] mem_dq_i
);
    amp_state_t state_r, state_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt, cslow_r;
    logic pend_r, cur_write_r, cur_page_r, pg_mode_r, last_write_r;
    logic [ADDR_W-1:0] cur_addr_r, addr_r;
    logic [DATA_W-1:0] cur_wdata_r, dq_s1_r, dq_s2_r;
    logic out_v_r, sp_v_r, out_v_nxt, sp_v_nxt;
    logic [DATA_W-1:0] out_d_r, sp_d_r, out_d_nxt, sp_d_nxt;
    logic accept, launch, push, pop, compat, cs_act, pend_nxt;

    function automatic logic [TMR_W-1:0] ld(input int c);
        return TMR_W'(c - 1);
    endfunction

    assign accept = req_valid && req_ready;
    assign pop = rsp_valid && rsp_ready;
    // page continuation only for the same open page and same direction
    assign compat = cur_page_r && pg_mode_r && (cur_write_r == last_write_r)
        && (cur_addr_r[ADDR_W-1:2] == addr_r[ADDR_W-1:2]);

    // pin data passes two flops before anything looks at it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
        end else if (ce) begin
            dq_s1_r <= mem_dq_i;
            dq_s2_r <= dq_s1_r;
        end
    end

    // sequencing of strobes; every wait is a whole-cycle count
    always_comb begin
        state_nxt = state_r;
        tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
        launch = 1'b0;
        push = 1'b0;
        unique case (state_r)
            AMP_IDLE: if (pend_r) begin
                launch = 1'b1;
                if (cur_page_r != pg_mode_r) begin
                    // mode pin moves only while selects are high
                    state_nxt = AMP_MODE;
                    tmr_nxt = cur_page_r ? ld(PGSL_CYC) : ld(PGX_CYC);
                end else begin
                    state_nxt = AMP_SETUP;
                end
            end
            AMP_MODE: if (tmr_r == '0) state_nxt = AMP_SETUP;
            AMP_SETUP: begin
                state_nxt = cur_write_r ? AMP_WLO : AMP_RWAIT;
                tmr_nxt = cur_write_r ? ld(WLO_CYC) : ld(ACC_CYC);
            end
            AMP_WLO: if (tmr_r == '0) begin
                state_nxt = AMP_WHI;
                tmr_nxt = ld(WHI_CYC);
            end
            AMP_WHI: if (tmr_r == '0) begin
                state_nxt = pg_mode_r ? AMP_PHOLD : AMP_END;
                tmr_nxt = ld(END_CYC);
            end
            AMP_RWAIT, AMP_PRWAIT: if (tmr_r == '0) begin
                push = 1'b1;
                state_nxt = pg_mode_r ? AMP_PHOLD : AMP_END;
                tmr_nxt = ld(END_CYC);
            end
            AMP_PHOLD: begin
                if (pend_r && compat) begin
                    launch = 1'b1;
                    state_nxt = cur_write_r ? AMP_PWLO : AMP_PRWAIT;
                    tmr_nxt = cur_write_r ? ld(PWLO_CYC) : ld(AAP_CYC);
                end else if (!req_valid && cslow_r >= TMR_W'(EP_CYC)) begin
                    // select may rise only after the page low time
                    state_nxt = AMP_END;
                    tmr_nxt = ld(END_CYC);
                end
            end
            AMP_PWLO: if (tmr_r == '0) begin
                state_nxt = AMP_PWHI;
                tmr_nxt = ld(PWHI_CYC);
            end
            AMP_PWHI: if (tmr_r == '0) state_nxt = AMP_PHOLD;
            AMP_END: if (tmr_r == '0) state_nxt = AMP_IDLE;
            default: state_nxt = AMP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= AMP_IDLE;
            tmr_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // request holding register; ready stays low until the access ends in AMP_IDLE or AMP_PHOLD
    assign pend_nxt = accept || (pend_r && !launch);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_r <= 1'b0;
            cur_write_r <= 1'b0;
            cur_page_r <= 1'b0;
            cur_addr_r <= '0;
            cur_wdata_r <= '0;
            req_ready <= 1'b0;
        end else if (ce) begin
            pend_r <= pend_nxt;
            if (accept) begin
                cur_write_r <= req_write;
                cur_page_r <= req_page;
                cur_addr_r <= req_addr;
                cur_wdata_r <= req_wdata;
            end
            // spare slot free means a started read always has room
            req_ready <= !pend_nxt && !sp_v_nxt
                && (state_nxt == AMP_IDLE || state_nxt == AMP_PHOLD);
        end
    end

    // selects counted low so a page access lasts long enough
    assign cs_act = !(state_nxt == AMP_IDLE || state_nxt == AMP_MODE
        || state_nxt == AMP_END);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cslow_r <= '0;
        end else if (ce) begin
            if (!cs_act) cslow_r <= '0;
            else if (cslow_r != '1) cslow_r <= cslow_r + 1'b1;
        end
    end

    function automatic logic addr_nxt_sel();
        return launch ? cur_addr_r[CS_SEL_BIT] : addr_r[CS_SEL_BIT];
    endfunction

    function automatic logic wr_nxt();
        return launch ? cur_write_r : last_write_r;
    endfunction

    // pin drivers, all registered from the next state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_r <= '0;
            mem_dq_o <= '0;
            pg_mode_r <= 1'b0; // legacy mode from reset
            last_write_r <= 1'b0;
            chip_select_lower_n <= 1'b1;
            chip_select_upper_n <= 1'b1;
            mem_we_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_dq_oe <= 1'b0;
        end else if (ce) begin
            if (launch) begin
                addr_r <= cur_addr_r;
                mem_dq_o <= cur_wdata_r;
                pg_mode_r <= cur_page_r;
                last_write_r <= cur_write_r;
            end
            chip_select_lower_n <= !(cs_act && !addr_nxt_sel());
            chip_select_upper_n <= !(cs_act && addr_nxt_sel());
            mem_we_n <= !(state_nxt == AMP_WLO || state_nxt == AMP_PWLO);
            mem_oe_n <= !(state_nxt == AMP_RWAIT || state_nxt == AMP_PRWAIT
                || (state_nxt == AMP_PHOLD && !wr_nxt()));
            mem_dq_oe <= wr_nxt() && state_nxt != AMP_PHOLD
                && cs_act;
        end
    end

    assign mem_addr = addr_r[PIN_ADDR_W-1:0];
    assign page_select_n = !pg_mode_r;

    // two-entry read buffer; receiver stall never drops a word
    always_comb begin
        out_v_nxt = out_v_r;
        out_d_nxt = out_d_r;
        sp_v_nxt = sp_v_r;
        sp_d_nxt = sp_d_r;
        if (pop) begin
            out_v_nxt = sp_v_r;
            out_d_nxt = sp_d_r;
            sp_v_nxt = 1'b0;
        end
        if (push && !out_v_nxt) begin
            out_v_nxt = 1'b1;
            out_d_nxt = dq_s2_r;
        end else if (push) begin
            sp_v_nxt = 1'b1;
            sp_d_nxt = dq_s2_r;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_v_r <= 1'b0;
            sp_v_r <= 1'b0;
            out_d_r <= '0;
            sp_d_r <= '0;
        end else if (ce) begin
            out_v_r <= out_v_nxt;
            sp_v_r <= sp_v_nxt;
            out_d_r <= out_d_nxt;
            sp_d_r <= sp_d_nxt;
        end
    end
    assign rsp_valid = out_v_r;
    assign rsp_rdata = out_d_r;

    logic cs_n;
    assign cs_n = chip_select_lower_n && chip_select_upper_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst || !ce);
    sequence s_wpulse;
        !mem_we_n [*4];
    endsequence

    AST_OE_HIGH_IN_WRITE: assert property (!mem_we_n |-> mem_oe_n)
        else $error("output gate low during write");
    AST_WE_HIGH_IN_READ: assert property (!mem_oe_n |-> mem_we_n)
        else $error("write strobe low during read");
    // a page pulse may fall on the edge that moves the address
    AST_ADDR_STABLE: assert property (!mem_we_n && $past(!mem_we_n)
        |-> $stable(mem_addr))
        else $error("address moved under write strobe");
    AST_WRITE_PULSE: assert property (
        $fell(mem_we_n) && page_select_n |-> s_wpulse)
        else $error("legacy write pulse too short");
    AST_ADDR_TO_END: assert property ($rose(mem_we_n) && page_select_n
        |-> $past(mem_addr, 4) == mem_addr)
        else $error("address not held before write end");
    AST_PG_SETUP: assert property ($fell(cs_n) |-> page_select_n
        == $past(page_select_n) && page_select_n
        == $past(page_select_n, 2))
        else $error("page select changed too close to select");
    AST_PG_HIGH: assert property ($rose(page_select_n)
        |-> page_select_n [*6])
        else $error("page select high time too short");
    AST_CS_DURING_WRITE: assert property (!mem_we_n |-> !cs_n)
        else $error("select high while writing");
    AST_CS_HIGH_TIME: assert property ($rose(cs_n) |-> cs_n [*2])
        else $error("select high time too short");
    AST_CS_LOW_PAGE: assert property ($fell(cs_n) && !page_select_n
        |-> !cs_n [*6])
        else $error("page select low time too short");
    // gate falls one cycle after select; both stay low for the access
    AST_READ_WAIT: assert property ($fell(mem_oe_n)
        |-> (!mem_oe_n && !cs_n) [*8])
        else $error("read sampled before access time");
endmodule

// ==== amp_mem_model.sv ====
// Purpose: behavioural x32 page-mode memory facing the host pins
// Assumes: no pull on the data lines, so lines that nobody drives toggle
// Notes: timing in ns, evaluated on a 0.5 ns grid
`timescale 1ns/10ps
module amp_mem_model import amp_pkg::*; (
    input wire logic [PIN_ADDR_W-1:0] mem_addr,
    input wire logic chip_select_lower_n,
    input wire logic chip_select_upper_n,
    input wire logic mem_we_n,
    input wire logic mem_oe_n,
    input wire logic page_select_n,
    input wire logic [DATA_W-1:0] mem_dq_o,
    input wire logic mem_dq_oe,
    output logic [DATA_W-1:0] mem_dq_i
);
    logic [DATA_W-1:0] arr [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0] wa;
    logic [ADDR_W-3:0] pg_r;
    logic sel_n;
    logic hit;
    logic pg_open = 1'h0;
    realtime t_acc = 0.0;
    realtime t_chg = 0.0;
    realtime t_oe = 0.0;
    assign sel_n = chip_select_lower_n & chip_select_upper_n;
    assign wa = {~chip_select_upper_n, mem_addr};
    // an in-page hit counts as 30 ns already spent, leaving 15 ns
    always @(negedge sel_n or mem_addr) begin
        hit = pg_open && wa[ADDR_W-1:2] == pg_r && $realtime > t_chg;
        t_chg = $realtime;
        if (!sel_n) begin
            t_acc = hit ? $realtime - 30.0 : $realtime;
            pg_r = wa[ADDR_W-1:2];
            pg_open = !page_select_n;
        end
    end
    // deselect drops the open page
    always @(posedge sel_n) pg_open = 1'h0;
    always @(negedge mem_oe_n) t_oe = $realtime;
    // a floating bus stores garbage, so a missing drive shows on readback
    always @(posedge mem_we_n) begin
        if (!sel_n) arr[wa] = mem_dq_oe ? mem_dq_o : 'x;
    end
    // unwritten words read back a pattern of their own address
    initial begin
        mem_dq_i = '0;
        forever begin
            #0.5;
            if (mem_dq_oe)
                mem_dq_i = mem_dq_o;
            else if (!sel_n && !mem_oe_n && mem_we_n &&
                     $realtime >= t_acc + 45.0 &&
                     $realtime >= t_oe + 25.0)
                mem_dq_i = arr.exists(wa) ? arr[wa] : {~wa[3:0], wa};
            else if ($realtime >= t_chg + 3.0)
                mem_dq_i = ~mem_dq_i;
        end
    end
endmodule

// ==== async_page_mode_memory_port_test.sv ====
// Purpose: self-checking run of the page-mode memory host
// Assumes: clk 125 MHz, inputs moved 1 ns after the rising edge
// Notes: pin timing is watched by event monitors in real time
`timescale 1ns/10ps
module async_page_mode_memory_port_test import amp_pkg::*;;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic req_valid = 1'h0;
    logic req_write = 1'h0;
    logic req_page = 1'h0;
    logic rsp_ready = 1'h1;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic req_ready, rsp_valid, chip_select_lower_n, chip_select_upper_n;
    logic mem_we_n, mem_oe_n, page_select_n, mem_dq_oe;
    logic [DATA_W-1:0] rsp_rdata, mem_dq_o, mem_dq_i;
    logic [PIN_ADDR_W-1:0] mem_addr;
    int fail_count = 0;
    int num_checks = 0;
    realtime t_we0 = -100.0, t_pg = 0.0, t_sf = 0.0, t_sr = -100.0;
    logic [PIN_ADDR_W-1:0] a_prev = '0;
    logic we_prev = 1'h1;
    wire sel_n = chip_select_lower_n & chip_select_upper_n;

    amp_host_ctrl amp_host_ctrl_i (.clk, .nrst, .ce(1'h1), .req_valid,
        .req_ready, .req_write, .req_page, .req_addr, .req_wdata,
        .rsp_valid, .rsp_ready, .rsp_rdata, .mem_addr, .chip_select_lower_n,
        .chip_select_upper_n, .mem_we_n, .mem_oe_n, .page_select_n,
        .mem_dq_o, .mem_dq_oe, .mem_dq_i);
    amp_mem_model amp_mem_model_i (.mem_addr, .chip_select_lower_n,
        .chip_select_upper_n, .mem_we_n, .mem_oe_n, .page_select_n,
        .mem_dq_o, .mem_dq_oe, .mem_dq_i);

    initial forever #4 clk = ~clk;

    task automatic chk_word(input string nm, input logic [DATA_W-1:0] exp,
                            input logic [DATA_W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_min(input string nm, input realtime lim,
                           input realtime got);
        num_checks++;
        if (got < lim) begin
            fail_count++;
            $display("[ERR] %s expected >= %0.1f seen %0.1f", nm, lim, got);
        end
    endtask

    // strobes looked at mid-cycle, where they have settled
    always @(negedge clk) begin
        if (nrst) chk_word("strobe_overlap", '0, 32'(!mem_we_n && !mem_oe_n));
        if (nrst && !mem_we_n && !we_prev)
            chk_word("addr_under_we", 32'(a_prev), 32'(mem_addr));
        a_prev = mem_addr;
        we_prev = mem_we_n;
    end
    always @(negedge mem_we_n) begin
        if (page_select_n) chk_min("write_cycle", T_AVAV_NS, $realtime - t_we0);
        t_we0 = $realtime;
    end
    // page pulses may be short, legacy pulses may not
    always @(posedge mem_we_n) begin
        if (nrst) chk_min("we_low", page_select_n ? T_WLWH_NS : T_WP_NS, $realtime - t_we0);
    end
    always @(page_select_n) begin
        if (!page_select_n && nrst) chk_min("page_high", T_PGH_NS, $realtime - t_pg);
        t_pg = $realtime;
    end
    always @(negedge sel_n) begin
        chk_min("mode_setup", T_PGSL_NS, $realtime - t_pg);
        chk_min("cs_high", T_EH_NS, $realtime - t_sr);
        t_sf = $realtime;
    end
    always @(posedge sel_n) begin
        if (nrst) chk_word("we_at_cs_rise", 32'h1, 32'(mem_we_n));
        if (nrst && !page_select_n) chk_min("cs_low", T_EP_NS, $realtime - t_sf);
        t_sr = $realtime;
    end

    // a request stays up until the edge that sees ready high
    task automatic send(input logic w, input logic pg,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        req_write = w;
        req_page = pg;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'h1;
        while (req_ready !== 1'h1 && n < 200) begin
            @(posedge clk) #1;
            n++;
        end
        chk_word("req_ready", 32'h1, 32'(req_ready));
        @(posedge clk) #1;
        req_valid = 1'h0;
        @(posedge clk) #1;
    endtask

    task automatic get(input logic [DATA_W-1:0] exp);
        int n;
        n = 0;
        while (rsp_valid !== 1'h1 && n < 200) begin
            @(posedge clk) #1;
            n++;
        end
        chk_word("rsp_valid", 32'h1, 32'(rsp_valid));
        chk_word("rsp_rdata", exp, rsp_rdata);
        @(posedge clk) #1;
    endtask

    task automatic t_reset();
        repeat (20) @(posedge clk) #1;
        chk_word("idle_pins", 32'h3f, {26'h0, chip_select_lower_n, chip_select_upper_n, mem_we_n, mem_oe_n, page_select_n, ~mem_dq_oe});
        chk_word("flags_in_reset", '0, {30'h0, req_ready, rsp_valid});
        nrst = 1'h1;
        @(posedge clk) #1;
        chk_word("ready_after_reset", 32'h1, 32'(req_ready));
        $display("test reset done");
    endtask

    // upper select must differ from lower: the unwritten alias reads pattern
    task automatic t_legacy();
        send(1'h1, 1'h0, 28'h8000123, 32'hdeadbeef);
        send(1'h1, 1'h0, 28'h0000124, 32'h01234567);
        send(1'h0, 1'h0, 28'h8000123, '0);
        get(32'hdeadbeef);
        send(1'h0, 1'h0, 28'h0000123, '0);
        get(32'hc0000123);
        $display("test legacy done");
    endtask

    task automatic t_page();
        for (int i = 0; i < 4; i++)
            send(1'h1, 1'h1, 28'h0000240 + 28'(i), 32'ha5a50000 + 32'(i));
        // two reads queued so the second one hits the open page
        rsp_ready = 1'h0;
        for (int i = 0; i < 4; i += 2) begin
            send(1'h0, 1'h1, 28'h0000242 - 28'(i), '0);
            send(1'h0, 1'h1, 28'h0000243 - 28'(i), '0);
            rsp_ready = 1'h1;
            get(32'ha5a50002 - 32'(i));
            get(32'ha5a50003 - 32'(i));
            rsp_ready = 1'h0;
        end
        rsp_ready = 1'h1;
        repeat (20) @(posedge clk) #1;
        send(1'h0, 1'h1, 28'h0000243, '0);
        get(32'ha5a50003);
        send(1'h0, 1'h0, 28'h0000241, '0);
        get(32'ha5a50001);
        $display("test page done");
    endtask

    // two words held by a stalled receiver, then drained in order
    task automatic t_stall();
        rsp_ready = 1'h0;
        send(1'h0, 1'h0, 28'h8000123, '0);
        send(1'h0, 1'h0, 28'h0000124, '0);
        repeat (40) @(posedge clk) #1;
        chk_word("full_flags", 32'h1, {30'h0, req_ready, rsp_valid});
        chk_word("held_word", 32'hdeadbeef, rsp_rdata);
        rsp_ready = 1'h1;
        get(32'hdeadbeef);
        get(32'h01234567);
        $display("test stall done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        t_reset();
        t_legacy();
        t_page();
        t_stall();
        close_out();
    end

    // the whole run needs well under 2000 cycles; 12500 means a hang
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
endmodule
